// ### dpr_core.sv
// Command decoder for precharge, burst terminate, refresh, self-refresh and
// mode register access, with eight per-bank trackers.
// Assumes CS, CKE and CA arrive synchronous to i_ref_clk; the falling-edge
// half of CA is presented on i_ca_f in the same cycle as i_ca_r.
`timescale 1ns/1ps
module dpr_core
  import dpr_pkg::*;
#(
  parameter int BL = BL_DEF,
  parameter int WL = WL_DEF,
  parameter int RL = RL_DEF
) (
  // Clock and reset
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_rstn,
  // Command pins
  input  wire logic                 i_cke,
  input  wire logic                 i_cs_n,
  input  wire logic [9:0]           i_ca_r,
  input  wire logic [9:0]           i_ca_f,
  // Bank status
  output logic [NUM_BANKS-1:0]      o_bank_open,
  output logic [NUM_BANKS-1:0]      o_bank_ap_pend,
  output logic [NUM_BANKS-1:0]      o_bank_pre_start,
  output logic [NUM_BANKS-1:0]      o_bank_rp_busy,
  // Burst terminate
  output logic                      o_burst_cut,
  output logic [5:0]                o_eff_bl,
  // Refresh
  output logic                      o_refresh,
  output logic                      o_refresh_all,
  output logic [13:0]               o_ref_row,
  output logic                      o_self_ref,
  // Mode registers
  output logic                      o_mrr_valid,
  output logic [7:0]                o_mrr_data,
  output logic                      o_mr_reset
);

  // ****************************************
  // Command decode
  // ****************************************
  dpr_state_e state_reg, state_next;
  logic       cke_prev_reg;
  logic [2:0] hold_reg, hold_next;
  logic [9:0] sr_cnt_reg, sr_cnt_next;
  logic [3:0] sr_min_reg, sr_min_next;
  logic [7:0] rfc_reg, rfc_next;
  logic [13:0] ref_row_next;
  logic [4:0] since_reg, since_next;
  logic       last_rd_reg, last_rd_next, live_reg, live_next;
  logic [3:0] cut_reg, cut_next;
  logic [5:0] eff_bl_next;
  logic [3:0] mrr_cnt_reg, mrr_cnt_next;
  logic [7:0] mrr_addr_reg, mrr_addr_next;
  logic       mrr_valid_next, refresh_next, refresh_all_next, mr_reset_next;
  logic [7:0] mrr_data_next;
  logic [7:0] mr_reg [MR_DEPTH];
  logic [7:0] mr_next [MR_DEPTH];

  logic       cmd_ok, all_idle;
  logic [7:0] mr_addr;
  logic [2:0] bank;
  logic       is_act, is_rd, is_wr, is_pre, is_pre_all, ap;

  // NOP and deselect match none of these, so running work goes on
  assign cmd_ok   = (state_reg == DPR_ACTIVE) && cke_prev_reg && i_cke && !i_cs_n
                    && hold_reg == 3'h0;
  assign all_idle = (o_bank_open == '0) && (o_bank_rp_busy == '0);
  assign mr_addr  = {i_ca_f[1:0], i_ca_r[9:MRA_R_LSB]};
  assign bank     = i_ca_r[BANK_LSB+2:BANK_LSB];
  assign ap       = i_ca_f[AP_BIT];
  assign is_act   = cmd_ok && i_ca_r[1:0] == CMD_ACT;
  assign is_rd    = cmd_ok && i_ca_r[2:0] == CMD_RD;
  assign is_wr    = cmd_ok && i_ca_r[2:0] == CMD_WR;
  assign is_pre   = cmd_ok && i_ca_r[3:0] == CMD_PRE;
  assign is_pre_all = is_pre && i_ca_r[PRE_ALL_BIT];

  always_comb begin
    state_next       = state_reg;
    hold_next        = (hold_reg != 3'h0) ? hold_reg - 3'h1 : hold_reg;
    sr_cnt_next      = sr_cnt_reg;
    sr_min_next      = (sr_min_reg != 4'h0) ? sr_min_reg - 4'h1 : sr_min_reg;
    rfc_next         = (rfc_reg != 8'h00) ? rfc_reg - 8'h01 : rfc_reg;
    ref_row_next     = o_ref_row;
    since_next       = (since_reg != 5'h1F) ? since_reg + 5'h01 : since_reg;
    last_rd_next     = last_rd_reg;
    live_next        = live_reg;
    cut_next         = (cut_reg != 4'h0) ? cut_reg - 4'h1 : cut_reg;
    eff_bl_next      = o_eff_bl;
    mrr_cnt_next     = (mrr_cnt_reg != 4'h0) ? mrr_cnt_reg - 4'h1 : mrr_cnt_reg;
    mrr_addr_next    = mrr_addr_reg;
    mrr_valid_next   = 1'b0;
    mrr_data_next    = 8'h00;
    refresh_next     = 1'b0;
    refresh_all_next = 1'b0;
    mr_reset_next    = 1'b0;
    for (int k = 0; k < MR_DEPTH; k++) begin
      mr_next[k] = mr_reg[k];
    end
    // Burst stays live only for its nominal length
    if (since_reg >= 5'(BL / 2)) begin
      live_next = 1'b0;
    end
    // Mode register data leaves RL cycles after the read, first beat only
    if (mrr_cnt_reg == 4'h1) begin
      mrr_valid_next = 1'b1;
      mrr_data_next  = (mrr_addr_reg < 8'(MR_DEPTH)) ? mr_reg[mrr_addr_reg[3:0]] : 8'h00;
    end
    case (state_reg)
      DPR_ACTIVE: begin
        if (is_rd || is_wr) begin
          since_next   = 5'h01;
          last_rd_next = is_rd;
          live_next    = !ap;
        end
        if (cmd_ok && i_ca_r[3:0] == CMD_BST && live_reg && !since_reg[0]) begin
          // Only the latest burst is cut; odd spacing is not legal and ignored
          eff_bl_next = {since_reg, 1'b0};
          cut_next    = last_rd_reg ? 4'(RL) : 4'(WL);
          live_next   = 1'b0;
        end
        if (cmd_ok && i_ca_r[2:0] == CMD_REF && rfc_reg == 8'h00) begin
          refresh_next     = 1'b1;
          refresh_all_next = i_ca_r[REF_ALL_BIT];
          ref_row_next     = o_ref_row + 14'h0001;
          rfc_next         = 8'(RFC_CYC);
        end
        if (cmd_ok && i_ca_r[3:0] == CMD_MRR) begin
          mrr_addr_next = mr_addr;
          mrr_cnt_next  = 4'(RL);
          hold_next     = 3'(MRR_CYC - 1);
        end
        if (cmd_ok && i_ca_r[3:0] == CMD_MRW) begin
          hold_next = 3'(MRW_CYC - 1);
          if (mr_addr == MR_RESET_ADDR) begin
            mr_reset_next = 1'b1;
            for (int k = 0; k < MR_DEPTH; k++) begin
              mr_next[k] = MR_RESET_VAL;
            end
          end else if (mr_addr < 8'(MR_DEPTH)) begin
            mr_next[mr_addr[3:0]] = {1'b0, i_ca_f[9:OP_LSB]};
          end
        end
        if (cke_prev_reg && !i_cke && !i_cs_n && i_ca_r[2:0] == CMD_REF && all_idle
            && hold_reg == 3'h0) begin
          state_next  = DPR_SELF;
          sr_cnt_next = 10'h001;
          sr_min_next = 4'(CKE_CYC);
        end
      end
      DPR_SELF: begin
        // Only CKE is watched; own timer refreshes first on the next cycle
        sr_cnt_next = sr_cnt_reg - 10'h001;
        if (sr_cnt_reg == 10'h001) begin
          refresh_next     = 1'b1;
          refresh_all_next = 1'b1;
          ref_row_next     = o_ref_row + 14'h0001;
          sr_cnt_next      = 10'(REFI_CYC);
        end
        if (i_cke && sr_min_reg == 4'h0) begin
          state_next = DPR_ACTIVE;
          rfc_next   = 8'(RFC_CYC);
        end
      end
      default: begin
        state_next = DPR_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg     <= DPR_ACTIVE;
      cke_prev_reg  <= 1'b0;
      hold_reg      <= 3'h0;
      sr_cnt_reg    <= 10'h000;
      sr_min_reg    <= 4'h0;
      rfc_reg       <= 8'h00;
      o_ref_row     <= 14'h0000;
      since_reg     <= 5'h1F;
      last_rd_reg   <= 1'b0;
      live_reg      <= 1'b0;
      cut_reg       <= 4'h0;
      o_eff_bl      <= 6'h00;
      mrr_cnt_reg   <= 4'h0;
      mrr_addr_reg  <= 8'h00;
      o_mrr_valid   <= 1'b0;
      o_mrr_data    <= 8'h00;
      o_refresh     <= 1'b0;
      o_refresh_all <= 1'b0;
      o_mr_reset    <= 1'b0;
      o_self_ref    <= 1'b0;
      o_burst_cut   <= 1'b0;
      for (int k = 0; k < MR_DEPTH; k++) begin
        mr_reg[k] <= MR_RESET_VAL;
      end
    end else begin
      state_reg     <= state_next;
      cke_prev_reg  <= i_cke;
      hold_reg      <= hold_next;
      sr_cnt_reg    <= sr_cnt_next;
      sr_min_reg    <= sr_min_next;
      rfc_reg       <= rfc_next;
      o_ref_row     <= ref_row_next;
      since_reg     <= since_next;
      last_rd_reg   <= last_rd_next;
      live_reg      <= live_next;
      cut_reg       <= cut_next;
      o_eff_bl      <= eff_bl_next;
      mrr_cnt_reg   <= mrr_cnt_next;
      mrr_addr_reg  <= mrr_addr_next;
      o_mrr_valid   <= mrr_valid_next;
      o_mrr_data    <= mrr_data_next;
      o_refresh     <= refresh_next;
      o_refresh_all <= refresh_all_next;
      o_mr_reset    <= mr_reset_next;
      o_self_ref    <= (state_next == DPR_SELF);
      o_burst_cut   <= (cut_reg == 4'h1);
      for (int k = 0; k < MR_DEPTH; k++) begin
        mr_reg[k] <= mr_next[k];
      end
    end
  end

  // ****************************************
  // Per-bank trackers
  // ****************************************
  localparam int AP_WR = WL + BL / 2 + WR_CYC;
  localparam int AP_RD = (BL / 2 > RTP_CYC) ? BL / 2 : RTP_CYC;

  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    dpr_bank #(
      .AP_WR_DLY (AP_WR),
      .AP_RD_DLY (AP_RD),
      .RP_DLY    (RP_CYC)
    ) u_bank (
      .i_ref_clk    (i_ref_clk),
      .i_rstn       (i_rstn),
      .i_act        (is_act && bank == 3'(b)),
      .i_rd         (is_rd && bank == 3'(b)),
      .i_wr         (is_wr && bank == 3'(b)),
      .i_ap         (ap),
      .i_pre        (is_pre && (is_pre_all || bank == 3'(b))),
      .i_force_idle (mr_reset_next),
      .o_open       (o_bank_open[b]),
      .o_ap_pend    (o_bank_ap_pend[b]),
      .o_pre_start  (o_bank_pre_start[b]),
      .o_rp_busy    (o_bank_rp_busy[b])
    );
  end

endmodule

// ### dpr_pkg.sv
// Constants shared by the command decoder and the per-bank tracker.
// Assumes a single 100 MHz command clock; all times are converted here.
package dpr_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int T_CK_PS      = 10000;
  localparam int T_WR_PS      = 15000;
  localparam int T_RP_PS      = 18000;
  localparam int T_RTP_PS     = 7500;
  localparam int T_RFC_PS     = 130000;
  localparam int T_REFI_PS    = 3900000;
  // Least times round up, the refresh interval is a longest time and rounds down
  localparam int WR_CYC       = (T_WR_PS + T_CK_PS - 1) / T_CK_PS;
  localparam int RP_CYC       = (T_RP_PS + T_CK_PS - 1) / T_CK_PS;
  localparam int RTP_CYC      = (T_RTP_PS + T_CK_PS - 1) / T_CK_PS;
  localparam int RFC_CYC      = (T_RFC_PS + T_CK_PS - 1) / T_CK_PS;
  localparam int REFI_CYC     = T_REFI_PS / T_CK_PS;
  localparam int CKE_CYC      = 3;
  localparam int MRR_CYC      = 2;
  localparam int MRW_CYC      = 5;
  localparam int BL_DEF       = 8;
  localparam int WL_DEF       = 2;
  localparam int RL_DEF       = 4;

  // ****************************************
  // Command bus encodings, CA0 is bit 0
  // ****************************************
  localparam logic [3:0] CMD_MRW    = 4'h0;
  localparam logic [3:0] CMD_MRR    = 4'h8;
  localparam logic [3:0] CMD_BST    = 4'h3;
  localparam logic [3:0] CMD_PRE    = 4'hB;
  localparam logic [2:0] CMD_REF    = 3'h4;
  localparam logic [2:0] CMD_WR     = 3'h1;
  localparam logic [2:0] CMD_RD     = 3'h5;
  localparam logic [1:0] CMD_ACT    = 2'h2;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int REF_ALL_BIT  = 3;
  localparam int PRE_ALL_BIT  = 4;
  localparam int BANK_LSB     = 7;
  localparam int AP_BIT       = 0;
  localparam int MRA_R_LSB    = 4;
  localparam int OP_LSB       = 3;
  localparam int NUM_BANKS    = 8;
  localparam int MR_DEPTH     = 16;
  localparam logic [7:0] MR_RESET_ADDR = 8'h3F;
  localparam logic [7:0] MR_RESET_VAL  = 8'h00;

  typedef enum logic [0:0] {
    DPR_ACTIVE,
    DPR_SELF
  } dpr_state_e;

endpackage

// ### dpr_bank.sv
// One bank's open/idle state, pending auto precharge and precharge period.
// Assumes command strobes are single-cycle and already qualified by the decoder.
`timescale 1ns/1ps
module dpr_bank
  import dpr_pkg::*;
#(
  parameter int AP_WR_DLY = 8,
  parameter int AP_RD_DLY = 4,
  parameter int RP_DLY    = 2
) (
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rstn,
  // Commands for this bank
  input  wire logic i_act,
  input  wire logic i_rd,
  input  wire logic i_wr,
  input  wire logic i_ap,
  input  wire logic i_pre,
  input  wire logic i_force_idle,
  // Bank status
  output logic      o_open,
  output logic      o_ap_pend,
  output logic      o_pre_start,
  output logic      o_rp_busy
);

  // ****************************************
  // Next state
  // ****************************************
  logic [7:0] ap_cnt_reg, ap_cnt_next;
  logic [7:0] rp_cnt_reg, rp_cnt_next;
  logic       open_next, ap_pend_next, pre_start_next;
  logic       start_pre;

  always_comb begin
    ap_cnt_next  = ap_cnt_reg;
    ap_pend_next = o_ap_pend;
    open_next    = o_open;
    rp_cnt_next  = (rp_cnt_reg != 8'h00) ? rp_cnt_reg - 8'h01 : rp_cnt_reg;
    // Auto precharge fires when its countdown expires
    start_pre    = i_pre || (o_ap_pend && ap_cnt_reg == 8'h01);
    if (o_ap_pend && ap_cnt_reg != 8'h00) begin
      ap_cnt_next = ap_cnt_reg - 8'h01;
    end
    if ((i_rd || i_wr) && i_ap) begin
      ap_pend_next = 1'b1;
      ap_cnt_next  = i_wr ? 8'(AP_WR_DLY) : 8'(AP_RD_DLY);
    end
    if (i_act) begin
      open_next = 1'b1;
    end
    if (start_pre) begin
      // Period restarts from the latest precharge that covered this bank
      open_next    = 1'b0;
      ap_pend_next = 1'b0;
      rp_cnt_next  = 8'(RP_DLY);
    end
    if (i_force_idle) begin
      open_next    = 1'b0;
      ap_pend_next = 1'b0;
    end
    pre_start_next = start_pre;
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ap_cnt_reg  <= 8'h00;
      rp_cnt_reg  <= 8'h00;
      o_open      <= 1'b0;
      o_ap_pend   <= 1'b0;
      o_pre_start <= 1'b0;
      o_rp_busy   <= 1'b0;
    end else begin
      ap_cnt_reg  <= ap_cnt_next;
      rp_cnt_reg  <= rp_cnt_next;
      o_open      <= open_next;
      o_ap_pend   <= ap_pend_next;
      o_pre_start <= pre_start_next;
      o_rp_busy   <= (rp_cnt_next != 8'h00);
    end
  end

endmodule

// ### dpr_core_monitor.sv
// Checker on the command decoder ports.
// Assumes it is bound to dpr_core and sees only its ports.
`timescale 1ns/1ps
module dpr_core_monitor
  import dpr_pkg::*;
#(
  parameter int BL = BL_DEF,
  parameter int WL = WL_DEF,
  parameter int RL = RL_DEF
) (
  // Clock, reset and command pins
  input wire logic                 i_ref_clk,
  input wire logic                 i_rstn,
  input wire logic                 i_cke,
  input wire logic                 i_cs_n,
  input wire logic [9:0]           i_ca_r,
  // Status outputs
  input wire logic [NUM_BANKS-1:0] o_bank_open,
  input wire logic [NUM_BANKS-1:0] o_bank_ap_pend,
  input wire logic [NUM_BANKS-1:0] o_bank_pre_start,
  input wire logic [NUM_BANKS-1:0] o_bank_rp_busy,
  input wire logic [5:0]           o_eff_bl,
  input wire logic                 o_refresh,
  input wire logic                 o_refresh_all,
  input wire logic                 o_self_ref,
  input wire logic                 o_mrr_valid,
  input wire logic                 o_mr_reset
);
  // ****************************************
  // Properties
  // ****************************************
  // Raw decode only; a refused read never yields data, so one direction suffices
  logic mrr_cmd;
  assign mrr_cmd = i_cke && !i_cs_n && (i_ca_r[3:0] == CMD_MRR);

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  chk_all_has_ref: assert property (o_refresh_all |-> o_refresh)
    else $error("all-bank flag without refresh pulse");
  chk_eff_bl_mult: assert property (o_eff_bl[1:0] == 2'b00)
    else $error("effective burst length not a multiple of four");
  chk_mrr_latency: assert property (o_mrr_valid |-> $past(mrr_cmd, RL + 1))
    else $error("mode register data without read RL cycles before");
  chk_pre_closes: assert property (|o_bank_pre_start |->
      (o_bank_pre_start & (o_bank_open | ~o_bank_rp_busy)) == 8'h00)
    else $error("precharge start without close and tRP");
  chk_rp_length: assert property (o_bank_pre_start[0] |=> o_bank_rp_busy[0] ##1
      (!o_bank_rp_busy[0] || o_bank_pre_start[0] || $past(o_bank_pre_start[0])))
    else $error("precharge period length wrong on bank 0");
  // A reset command may legally close a bank with auto precharge still pending
  chk_ap_clears: assert property ($fell(o_bank_ap_pend[0]) |->
      (o_bank_pre_start[0] || $past(o_bank_pre_start[0]) || o_mr_reset))
    else $error("pending auto precharge dropped without precharge");
  // Window spans the read delay and the longer write recovery delay
  chk_ap_delay: assert property ($rose(o_bank_ap_pend[0]) |->
      (!o_bank_pre_start[0])[*3] ##[1:6] o_bank_pre_start[0])
    else $error("auto precharge start out of window");
  chk_sref_entry: assert property ($rose(o_self_ref) |->
      !$past(i_cke, 1) && $past(i_cke, 2))
    else $error("self-refresh entered without clock enable falling");
  chk_sref_hold: assert property ($rose(o_self_ref) |-> o_self_ref[*3])
    else $error("self-refresh left before minimum time");
  chk_sref_ref: assert property ($rose(o_self_ref) |-> ##[0:3] o_refresh)
    else $error("no internal refresh after self-refresh entry");
endmodule

bind dpr_core dpr_core_monitor #(.BL(BL), .WL(WL), .RL(RL)) u_mon (
  .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_cke(i_cke), .i_cs_n(i_cs_n),
  .i_ca_r(i_ca_r), .o_bank_open(o_bank_open), .o_bank_ap_pend(o_bank_ap_pend),
  .o_bank_pre_start(o_bank_pre_start), .o_bank_rp_busy(o_bank_rp_busy),
  .o_eff_bl(o_eff_bl), .o_refresh(o_refresh), .o_refresh_all(o_refresh_all),
  .o_self_ref(o_self_ref), .o_mrr_valid(o_mrr_valid), .o_mr_reset(o_mr_reset));

// ### dpr_ctrl_model.sv
// Controller model driving the command pins.
// Assumes callers enter its tasks just after a falling clock edge.
`timescale 1ns/1ps
module dpr_ctrl_model (
  // Clock
  input  wire logic       i_ref_clk,
  // Command pins
  output logic            o_cke,
  output logic            o_cs_n,
  output logic [9:0]      o_ca_r,
  output logic [9:0]      o_ca_f
);
  initial begin
    o_cke  = 1'b1;
    o_cs_n = 1'b1;
    o_ca_r = 10'h000;
    o_ca_f = 10'h000;
  end
  // One command for one rising edge; the caller keeps the spacing
  task automatic cmd(input logic k, input logic [9:0] r, input logic [9:0] f);
    o_cke  = k;
    o_cs_n = 1'b0;
    o_ca_r = r;
    o_ca_f = f;
    @(negedge i_ref_clk);
  endtask
  // Deselect; CA flipped so stale values never look valid
  task automatic idle();
    o_cs_n = 1'b1;
    o_ca_r = ~o_ca_r;
    o_ca_f = ~o_ca_f;
  endtask
  // Clock never stops here, so exit always sees it running
  task automatic cke_set(input logic k);
    o_cke = k;
  endtask
endmodule

// ### dpr_core_tb.sv
// Self-checking bench for the command decoder.
// Assumes the package default burst length and latencies.
`timescale 1ns/1ps
module dpr_core_tb
  import dpr_pkg::*;
;
  localparam int AP_WR = WL_DEF + BL_DEF / 2 + WR_CYC;
  logic                 i_ref_clk;
  logic                 i_rstn;
  logic                 cke;
  logic                 cs_n;
  logic [9:0]           ca_r;
  logic [9:0]           ca_f;
  logic [NUM_BANKS-1:0] bank_open;
  logic [NUM_BANKS-1:0] ap_pend;
  logic [NUM_BANKS-1:0] pre_start;
  logic [NUM_BANKS-1:0] rp_busy;
  logic                 burst_cut;
  logic [5:0]           eff_bl;
  logic                 refresh;
  logic                 refresh_all;
  logic [13:0]          ref_row;
  logic                 self_ref;
  logic                 mrr_valid;
  logic [7:0]           mrr_data;
  logic                 mr_reset;
  int                   error_cnt;
  int                   samples_checked;

`define CHK(nm, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("ERROR %s expected %0h seen %0h", nm, exp, got); \
    end \
  end

  initial i_ref_clk = 1'b0;
  always #5 i_ref_clk = ~i_ref_clk;

  dpr_ctrl_model ctl (.i_ref_clk(i_ref_clk), .o_cke(cke), .o_cs_n(cs_n),
    .o_ca_r(ca_r), .o_ca_f(ca_f));
  dpr_core #(.BL(BL_DEF), .WL(WL_DEF), .RL(RL_DEF)) dut (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_cke(cke), .i_cs_n(cs_n),
    .i_ca_r(ca_r), .i_ca_f(ca_f), .o_bank_open(bank_open),
    .o_bank_ap_pend(ap_pend), .o_bank_pre_start(pre_start),
    .o_bank_rp_busy(rp_busy), .o_burst_cut(burst_cut), .o_eff_bl(eff_bl),
    .o_refresh(refresh), .o_refresh_all(refresh_all), .o_ref_row(ref_row),
    .o_self_ref(self_ref), .o_mrr_valid(mrr_valid), .o_mrr_data(mrr_data),
    .o_mr_reset(mr_reset));

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic step(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask

  task automatic t_wrap();
    ctl.cmd(1'b1, 10'h002, 10'h000);
    ctl.cmd(1'b1, 10'h082, 10'h000);
    ctl.idle();
    step(1);
    ctl.cmd(1'b1, 10'h001, 10'h001);
    ctl.idle();
    step(1);
    `CHK("ap_pend0", 1'b1, ap_pend[0])
    ctl.cmd(1'b1, 10'h007, 10'h000);
    ctl.idle();
    step(AP_WR - 3);
    `CHK("pre0_early", 1'b0, pre_start[0])
    step(1);
    `CHK("pre0", 1'b1, pre_start[0])
    `CHK("open_ap", 8'h02, bank_open)
    step(2);
    `CHK("rp0", 1'b0, rp_busy[0])
  endtask

  task automatic t_bst();
    ctl.cmd(1'b1, 10'h202, 10'h000);
    ctl.idle();
    step(1);
    ctl.cmd(1'b1, 10'h205, 10'h000);
    ctl.idle();
    step(1);
    ctl.cmd(1'b1, 10'h003, 10'h000);
    ctl.idle();
    step(RL_DEF - 1);
    `CHK("cut_early", 1'b0, burst_cut)
    step(1);
    `CHK("cut", 1'b1, burst_cut)
    `CHK("eff_bl", 6'h04, eff_bl)
    ctl.cmd(1'b1, 10'h201, 10'h000);
    ctl.cmd(1'b1, 10'h003, 10'h000);
    ctl.idle();
    repeat (WL_DEF + 3) begin
      step(1);
      `CHK("odd_cut", 1'b0, burst_cut)
    end
  endtask

  task automatic t_pre();
    ctl.cmd(1'b1, 10'h102, 10'h000);
    ctl.idle();
    step(1);
    ctl.cmd(1'b1, 10'h08B, 10'h000);
    ctl.cmd(1'b1, 10'h01B, 10'h000);
    ctl.idle();
    `CHK("pre1", 1'b1, pre_start[1])
    step(1);
    `CHK("pre_all", 8'h00, bank_open)
    `CHK("rp1_late", 1'b1, rp_busy[1])
    step(1);
    step(1);
    `CHK("rp_done", 8'h00, rp_busy)
  endtask

  task automatic t_ref();
    ctl.cmd(1'b1, 10'h00C, 10'h000);
    `CHK("ref_all", 2'b11, {refresh, refresh_all})
    ctl.cmd(1'b1, 10'h004, 10'h000);
    ctl.idle();
    step(1);
    `CHK("ref_rfc", 15'h0001, {refresh, ref_row})
    step(RFC_CYC);
    ctl.cmd(1'b1, 10'h004, 10'h000);
    ctl.idle();
    `CHK("ref_bank", 2'b10, {refresh, refresh_all})
    step(1);
    `CHK("ref_row", 14'h0002, ref_row)
  endtask

  task automatic t_mr();
    ctl.cmd(1'b1, 10'h050, {7'h5A, 3'h0});
    ctl.cmd(1'b1, 10'h050, {7'h11, 3'h0});
    ctl.idle();
    step(MRW_CYC);
    ctl.cmd(1'b1, 10'h058, 10'h000);
    ctl.cmd(1'b1, 10'h068, 10'h000);
    ctl.idle();
    step(RL_DEF - 2);
    `CHK("mrr_early", 1'b0, mrr_valid)
    step(1);
    `CHK("mrr_data", 9'h15A, {mrr_valid, mrr_data})
    step(1);
    `CHK("mrr_once", 1'b0, mrr_valid)
    ctl.cmd(1'b1, 10'h182, 10'h000);
    ctl.idle();
    step(1);
    ctl.cmd(1'b1, 10'h3F0, 10'h000);
    ctl.idle();
    `CHK("mr_reset", 1'b1, mr_reset)
    step(1);
    step(MRW_CYC);
    `CHK("rst_close", 8'h00, bank_open)
  endtask

  task automatic t_sref();
    ctl.cmd(1'b0, 10'h004, 10'h000);
    ctl.idle();
    step(1);
    `CHK("sref_in", 1'b1, self_ref)
    ctl.cmd(1'b0, 10'h3F0, 10'h000);
    ctl.idle();
    `CHK("sref_mute", 1'b0, mr_reset)
    step(1);
    step(1);
    `CHK("sref_row", 14'h0003, ref_row)
    ctl.cke_set(1'b1);
    step(2);
    `CHK("sref_out", 1'b0, self_ref)
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    error_cnt = 0;
    samples_checked = 0;
    i_rstn = 1'b0;
    repeat (10) @(negedge i_ref_clk);
    `CHK("rst_out", 1'b0, |{bank_open, ref_row, self_ref, rp_busy})
    i_rstn = 1'b1;
    step(2);
    t_wrap();
    t_bst();
    t_pre();
    step(RP_CYC);
    t_ref();
    t_mr();
    t_sref();
    close_out();
  end

  // Run needs about a hundred cycles; a hang is cut at about twenty times that
  initial begin
    #20000;
    error_cnt++;
    close_out();
  end
endmodule
